// *** cmb_bus_model.sv ***
// cmb_bus_model: protocol engine and cable side of the can bus, seen from the buffer manager
// assumes the same hclk as the buffer manager; pulses start one edge after each call
`timescale 1ns/1ps
module cmb_bus_model
  import cmb_pkg::*;
(
  input  wire logic   hclk,   // system clock
  input  wire logic   tx_pin, // transmit pin of the device
  output logic        rx_pin, // wired level of the cable
  output cmb_rx_evt_t rx_evt, // receive events
  output cmb_tx_evt_t tx_evt  // transmit events
);
  logic other_bit;
  assign rx_pin = tx_pin & other_bit; // low from anyone is dominant on the cable
  initial
  begin
    rx_evt = '0;
    tx_evt = 9'h001;
    other_bit = 1'b1;
  end
  task automatic drive(input logic v);
    @(posedge hclk) other_bit <= v;
  endtask
  // whole frame: start, thirteen bytes counting up from b0, then the end with its qualifiers
  task automatic frame(input logic [7:0] b0, input logic acc, input logic own);
    @(posedge hclk) rx_evt <= 13'h1000;
    for (int k = 0; k < BUF_BYTES; k++)
      @(posedge hclk) rx_evt <= {2'b01, b0 + k[7:0], 3'b000};
    @(posedge hclk) rx_evt <= {10'h000, 1'b1, acc, own};
    @(posedge hclk) rx_evt <= '0;
  endtask
  task automatic tx_pulse(input logic [8:0] v);
    @(posedge hclk) tx_evt <= v;
    @(posedge hclk) tx_evt <= 9'h001;
    // one more edge so the caller reads the settled answer, not the launching edge
    @(posedge hclk);
  endtask
endmodule

// *** cmb_can_buffer_mgr.sv ***
// cmb_can_buffer_mgr: receive fifo, three prioritised transmit buffers, abort handshake, pins
// assumes a protocol engine on hclk that serialises frames and reports per-frame events
// Notes on behaviour
// R1: transmit pin low is dominant, high is recessive; receive is a separate input.
// R2: receive sits on port bit 0, transmit on port bit 1.
// R3: received frames pass background buffer then host-visible foreground buffer.
// R4: each receive buffer holds 13 bytes: control, identifier, data.
// R5: rx full flag set when foreground holds a good, accepted message.
// R6: every frame is written to background regardless of filter result.
// R7: accepted good frame copies to foreground, sets rx full, only when flag clear.
// R8: host reads foreground then clears rx full by writing one.
// R9: receive interrupt gated by its enable; flag pollable when masked.
// R10: own transmitted frames go to background only, no copy, no irq, no ack.
// R11: in loop-back own frames are treated like any received frame.
// R12: after lost arbitration the winning frame is received normally.
// R13: both buffers full plus another accepted frame: drop it, flag overrun.
// R14: while both buffers full, transmit continues and every incoming frame is dropped.
// R15: three 13-byte transmit buffers, each with an 8-bit local priority.
// R16: host loads an empty buffer then clears its tx empty flag.
// R17: ready buffers are sent; success sets tx empty and raises transmit irq if enabled.
// R18: among ready buffers the lowest priority value goes first.
// R19: selection repeats at every arbitration, also after an error.
// R20: abort request granted unless in flight: sets abort ack, tx empty, irq.
// R21: abort ack reads 1 if aborted, 0 if sent.
// R22: clearing tx empty also clears that buffer's abort ack.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module cmb_can_buffer_mgr #(
  parameter int NUM_TX = cmb_pkg::TX_BUFS
) (
  input  wire logic                 hclk,          // system clock
  input  wire logic                 hresetn,       // async reset, active low
  input  wire logic                 ce,            // clock enable, freezes all state when low
  input  wire logic                 hsel,          // ahb slave select
  input  wire logic [31:0]          haddr,         // ahb address
  input  wire logic [1:0]           htrans,        // ahb transfer type
  input  wire logic                 hwrite,        // ahb write
  input  wire logic [2:0]           hsize,         // ahb size, word only
  input  wire logic                 hready,        // ahb bus ready
  input  wire logic [31:0]          hwdata,        // ahb write data
  output logic [31:0]               hrdata,        // ahb read data
  output logic                      hreadyout,     // ahb slave ready
  output logic                      hresp,         // ahb response, always okay
  input  wire logic [1:0]           port_pins_in,  // port levels, bit 0 receive
  output logic [1:0]                port_pins_out, // port drive, bit 1 transmit
  output logic [1:0]                port_pins_oe,  // port drive enables
  input  wire cmb_pkg::cmb_rx_evt_t rx_evt,        // receive events from engine
  input  wire cmb_pkg::cmb_tx_evt_t tx_evt,        // transmit events from engine
  output cmb_pkg::cmb_tx_ans_t      tx_ans,        // answers to engine
  output logic                      rx_irq,        // receive interrupt, level
  output logic                      tx_irq,        // transmit interrupt, level
  output logic                      err_irq        // overrun interrupt, level
);
  import cmb_pkg::*;

  if (NUM_TX < 1 || NUM_TX > TX_BUFS)
  begin : g_bad_num_tx
    $error("NUM_TX must be 1 to 3");
  end

  logic [7:0]        bg_mem [BUF_BYTES];
  logic [7:0]        fg_mem [BUF_BYTES];
  logic [7:0]        tx_mem [NUM_TX][BUF_BYTES];
  logic [7:0]        local_priority_field_reg [NUM_TX];
  logic              rx_meta_reg;
  logic              rx_sync_reg;
  logic              tx_pin_reg;
  logic [3:0]        bg_idx_reg;
  logic              rx_full_reg;
  logic              bg_held_reg;
  logic              ovr_reg;
  logic              loop_reg;
  logic              rxie_reg;
  logic              ovrie_reg;
  logic [NUM_TX-1:0] txe_reg;
  logic [NUM_TX-1:0] abort_ack_flag_reg;
  logic [NUM_TX-1:0] abort_request_flag_reg;
  logic [NUM_TX-1:0] txie_reg;
  logic              tx_busy_reg;
  logic [1:0]        tx_sel_reg;
  logic [7:0]        tx_data_reg;
  cmb_ahb_st_t       ahb_st_reg;
  logic [11:0]       addr_reg;
  logic [31:0]       hrdata_reg;

  // ---------------- pins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_meta_reg <= PIN_RECESSIVE;
      rx_sync_reg <= PIN_RECESSIVE;
      tx_pin_reg  <= PIN_RECESSIVE;
    end
    else if (ce)
    begin
      rx_meta_reg <= port_pins_in[PIN_RX];
      rx_sync_reg <= rx_meta_reg;
      tx_pin_reg  <= tx_evt.tx_bit;                       // [R1]
    end
  end

  always_comb
  begin
    port_pins_out         = '1;
    port_pins_out[PIN_TX] = tx_pin_reg;                   // [R2]
    port_pins_oe          = '0;
    port_pins_oe[PIN_TX]  = 1'b1;                         // [R2]
  end

  // ---------------- ahb-lite slave: writes zero wait, reads one wait state
  logic       take;
  logic       wr_en;
  logic [3:0] widx;
  logic [1:0] bsel;
  logic       tx_win;
  logic [1:0] tx_b;
  logic [31:0] rd_val;

  assign take      = hsel & htrans[1] & hready;
  assign wr_en     = ce & (ahb_st_reg == CMB_AHB_WR);
  assign hreadyout = (ahb_st_reg != CMB_AHB_RDW);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;
  assign widx      = addr_reg[WIDX_MSB:WIDX_LSB];
  assign bsel      = addr_reg[BSEL_MSB:BSEL_LSB];
  assign tx_b      = bsel - 2'h1;
  assign tx_win    = (addr_reg[11:CTL_BIT] == '0) && (bsel != 2'h0) && (int'(tx_b) < NUM_TX);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ahb_st_reg <= CMB_AHB_IDLE;
      addr_reg   <= 12'h000;
    end
    else if (ce)
    begin
      case (ahb_st_reg)
        CMB_AHB_RDW: ahb_st_reg <= CMB_AHB_RD;
        default:
        begin
          if (take)
          begin
            ahb_st_reg <= hwrite ? CMB_AHB_WR : CMB_AHB_RDW;
            addr_reg   <= haddr[11:0];
          end
          else
            ahb_st_reg <= CMB_AHB_IDLE;
        end
      endcase
    end
  end

  always_comb
  begin
    rd_val = 32'h0000_0000;
    case (addr_reg)
      RXFLG_OFF:
      begin
        rd_val[RXF_BIT] = rx_full_reg;                    // [R5]
        rd_val[OVR_BIT] = ovr_reg;
      end
      TXFLG_OFF:
      begin
        rd_val[TXE_LSB +: NUM_TX]   = txe_reg;
        rd_val[ABORT_ACK_FLAG_LSB +: NUM_TX] = abort_ack_flag_reg;          // [R21]
      end
      TXCTL_OFF:
      begin
        rd_val[ABORT_REQUEST_FLAG_LSB +: NUM_TX] = abort_request_flag_reg;
        rd_val[TXIE_LSB +: NUM_TX]  = txie_reg;
      end
      MCTL_OFF:
      begin
        rd_val[LOOP_BIT]  = loop_reg;
        rd_val[RXIE_BIT]  = rxie_reg;
        rd_val[OVRIE_BIT] = ovrie_reg;
      end
      default:
      begin
        // one fixed window shows whichever message is in the foreground
        if (addr_reg[11:BSEL_LSB] == RX_BUF_OFF[11:BSEL_LSB] && int'(widx) < BUF_BYTES)
          rd_val[7:0] = fg_mem[widx];                     // [R3]
        else if (tx_win && int'(widx) < BUF_BYTES)
          rd_val[7:0] = tx_mem[tx_b][widx];
        else if (tx_win && widx == LOCAL_PRIORITY_FIELD_IDX)
          rd_val[7:0] = local_priority_field_reg[tx_b];
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_reg <= 32'h0000_0000;
    else if (ce && ahb_st_reg == CMB_AHB_RDW)
      hrdata_reg <= rd_val;
  end

  logic wr_rxflg;
  logic wr_txflg;
  logic wr_txctl;
  logic wr_mctl;
  logic [NUM_TX-1:0] txe_clr;

  assign wr_rxflg = wr_en && addr_reg == RXFLG_OFF;
  assign wr_txflg = wr_en && addr_reg == TXFLG_OFF;
  assign wr_txctl = wr_en && addr_reg == TXCTL_OFF;
  assign wr_mctl  = wr_en && addr_reg == MCTL_OFF;
  assign txe_clr  = wr_txflg ? hwdata[TXE_LSB +: NUM_TX] : '0;   // [R16]

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      loop_reg  <= 1'b0;
      rxie_reg  <= 1'b0;
      ovrie_reg <= 1'b0;
      txie_reg  <= '0;
    end
    else if (wr_mctl)
    begin
      loop_reg  <= hwdata[LOOP_BIT];
      rxie_reg  <= hwdata[RXIE_BIT];
      ovrie_reg <= hwdata[OVRIE_BIT];
    end
    else if (wr_txctl)
      txie_reg <= hwdata[TXIE_LSB +: NUM_TX];
  end

  // a scheduled buffer is locked against writes so the engine never sees a half-loaded frame
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < NUM_TX; i++)
        local_priority_field_reg[i] <= 8'h00;
    end
    else if (wr_en && tx_win && txe_reg[tx_b] && widx == LOCAL_PRIORITY_FIELD_IDX)
      local_priority_field_reg[tx_b] <= hwdata[7:0];                      // [R15]
  end

  always_ff @(posedge hclk)
  begin
    if (wr_en && tx_win && txe_reg[tx_b] && int'(widx) < BUF_BYTES)
      tx_mem[tx_b][widx] <= hwdata[7:0];                  // [R15]
  end

  // ---------------- receive fifo
  logic frame_counts;
  logic bg_we;
  logic copy_fg;
  logic rxf_next;
  logic held_next;
  logic ovr_set;
  logic rxf_clr;

  // own frames count only in loop-back; a lost arbitration arrives as a foreign frame
  assign frame_counts = rx_evt.ok & rx_evt.accept & (~rx_evt.own | loop_reg);  // [R10] [R11] [R12]
  assign bg_we   = ce & rx_evt.byte_valid & ~bg_held_reg & (int'(bg_idx_reg) < BUF_BYTES); // [R6] [R14]
  assign rxf_clr = wr_rxflg & hwdata[RXF_BIT];            // [R8]

  always_comb
  begin
    copy_fg   = 1'b0;
    rxf_next  = rx_full_reg;
    held_next = bg_held_reg;
    ovr_set   = 1'b0;
    if (bg_held_reg && !rx_full_reg)
    begin
      copy_fg   = 1'b1;
      rxf_next  = 1'b1;
      held_next = 1'b0;
    end
    else if (rxf_clr)
    begin
      if (bg_held_reg)
      begin
        copy_fg   = 1'b1;
        held_next = 1'b0;
      end
      else
        rxf_next = 1'b0;
    end
    if (frame_counts)
    begin
      if (bg_held_reg)
        ovr_set = 1'b1;                                   // [R13]
      else if (!rx_full_reg)
      begin
        copy_fg  = 1'b1;                                  // [R7]
        rxf_next = 1'b1;                                  // [R5]
      end
      else
        held_next = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_full_reg <= 1'b0;
      bg_held_reg <= 1'b0;
      ovr_reg     <= 1'b0;
      bg_idx_reg  <= 4'h0;
    end
    else if (ce)
    begin
      rx_full_reg <= rxf_next;
      bg_held_reg <= held_next;
      ovr_reg     <= ovr_set | (ovr_reg & ~(wr_rxflg & hwdata[OVR_BIT]));
      if (rx_evt.sof)
        bg_idx_reg <= 4'h0;
      else if (bg_we)
        bg_idx_reg <= bg_idx_reg + 4'h1;
    end
  end

  always_ff @(posedge hclk)
  begin
    if (bg_we)
      bg_mem[bg_idx_reg] <= rx_evt.data;                  // [R4] [R6]
    if (ce && copy_fg)
      fg_mem <= bg_mem;                                   // [R3]
  end

  assign rx_irq  = rx_full_reg & rxie_reg;                // [R9]
  assign err_irq = ovr_reg & ovrie_reg;                   // [R13]

  // ---------------- transmit scheduling
  logic [NUM_TX-1:0] ready;
  logic [NUM_TX-1:0] grant;
  logic [NUM_TX-1:0] sel_1h;
  logic [NUM_TX-1:0] sent_1h;
  logic [1:0]        best_sel;
  logic [7:0]        best_local_priority_field;
  logic              best_ok;
  logic              start;
  logic              tx_fin;

  assign ready  = ~txe_reg;
  assign start  = ce & tx_evt.arb & tx_ans.pending;       // [R19]
  assign tx_fin = tx_busy_reg & (tx_evt.done_ok | tx_evt.arb_lost | tx_evt.error);

  always_comb
  begin
    best_ok   = 1'b0;
    best_sel  = 2'h0;
    best_local_priority_field = 8'hFF;
    for (int i = 0; i < NUM_TX; i++)
    begin
      sel_1h[i]  = (tx_sel_reg == 2'(i));
      sent_1h[i] = sel_1h[i] & tx_busy_reg & tx_evt.done_ok;
      if (ready[i] && (!best_ok || local_priority_field_reg[i] < best_local_priority_field))
      begin
        best_ok   = 1'b1;                                 // [R18]
        best_sel  = 2'(i);
        best_local_priority_field = local_priority_field_reg[i];
      end
    end
    grant = abort_request_flag_reg & ready;
    if (tx_busy_reg)
      grant[tx_sel_reg] = 1'b0;                           // [R20]
    if (start)
      grant[best_sel] = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_busy_reg <= 1'b0;
      tx_sel_reg  <= 2'h0;
    end
    else if (ce)
    begin
      if (start)
      begin
        tx_busy_reg <= 1'b1;
        tx_sel_reg  <= best_sel;                          // [R18]
      end
      else if (tx_fin)
        tx_busy_reg <= 1'b0;                              // [R19]
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      txe_reg   <= {NUM_TX{TXE_RST}};
      abort_ack_flag_reg <= '0;
      abort_request_flag_reg <= '0;
    end
    else if (ce)
    begin
      txe_reg   <= (txe_reg & ~txe_clr) | grant | sent_1h;              // [R17] [R20]
      abort_ack_flag_reg <= (abort_ack_flag_reg & ~txe_clr & ~sent_1h) | grant;           // [R21] [R22]
      abort_request_flag_reg <= (wr_txctl ? hwdata[ABORT_REQUEST_FLAG_LSB +: NUM_TX] : abort_request_flag_reg)
                   & ~grant & ~sent_1h & ~(txe_reg & ~txe_clr);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tx_data_reg <= 8'h00;
    else if (ce)
      tx_data_reg <= (int'(tx_evt.rd_idx) < BUF_BYTES) ? tx_mem[tx_sel_reg][tx_evt.rd_idx] : 8'h00;
  end

  assign tx_irq = |(txe_reg & txie_reg);                  // [R17]

  always_comb
  begin
    tx_ans.pending   = best_ok & ~tx_busy_reg;
    tx_ans.busy      = tx_busy_reg;
    tx_ans.sel       = tx_sel_reg;
    tx_ans.data      = tx_data_reg;
    tx_ans.ack_allow = loop_reg | ~tx_busy_reg;           // [R10]
    tx_ans.rx_bit    = loop_reg ? tx_pin_reg : rx_sync_reg;  // [R11]
  end

  // ---------------- assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_tx_pin;
    ce |=> port_pins_out[PIN_TX] == $past(tx_evt.tx_bit);
  endproperty
  a_tx_pin: assert property (p_tx_pin) else $error("transmit pin not following engine level"); // [R1]

  property p_pin_pos;
    port_pins_oe[PIN_TX] && !port_pins_oe[PIN_RX];
  endproperty
  a_pin_pos: assert property (p_pin_pos) else $error("port pin roles wrong"); // [R2]

  property p_copy;
    ce && frame_counts && !bg_held_reg && !rx_full_reg |=> rx_full_reg && fg_mem[0] == $past(bg_mem[0]);
  endproperty
  a_copy: assert property (p_copy) else $error("accepted frame not copied to foreground"); // [R7]

  property p_ovr;
    // a host clear in the same cycle legally promotes the held frame, so it is left out here
    ce && frame_counts && bg_held_reg && !rxf_clr |=> ovr_reg && bg_held_reg && rx_full_reg;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not flagged"); // [R13]

  property p_held_drop;
    bg_held_reg && !rx_evt.sof |=> $stable(bg_idx_reg);
  endproperty
  a_held_drop: assert property (p_held_drop) else $error("held background buffer overwritten"); // [R14]

  property p_own_no_ack;
    tx_busy_reg && !loop_reg |-> !tx_ans.ack_allow;
  endproperty
  a_own_no_ack: assert property (p_own_no_ack) else $error("own frame acknowledged"); // [R10]

  property p_sent;
    ce && tx_busy_reg && tx_evt.done_ok |=> txe_reg[$past(tx_sel_reg)] && !abort_ack_flag_reg[$past(tx_sel_reg)]
                                           && !tx_busy_reg;
  endproperty
  a_sent: assert property (p_sent) else $error("sent buffer not released"); // [R21]

  property p_abort;
    ce && grant != '0 |=> (txe_reg & abort_ack_flag_reg & $past(grant)) == $past(grant);
  endproperty
  a_abort: assert property (p_abort) else $error("abort grant incomplete"); // [R20]

  for (genvar g = 0; g < NUM_TX; g++)
  begin : g_local_priority_field_chk
    property p_local_priority_field;
      start && ready[g] |=> local_priority_field_reg[tx_sel_reg] <= $past(local_priority_field_reg[g]) && tx_busy_reg;
    endproperty
    a_local_priority_field: assert property (p_local_priority_field) else $error("lower priority buffer chosen"); // [R18]
  end

  c_overrun:  cover property (ce && frame_counts && bg_held_reg);
  c_abort:    cover property (ce && grant != '0);
  c_loopback: cover property (ce && loop_reg && rx_evt.own && frame_counts);
  c_retry:    cover property (ce && tx_busy_reg && tx_evt.error ##[1:50] start);
endmodule

// *** cmb_can_buffer_mgr_tb_top.sv ***
// cmb_can_buffer_mgr_tb_top: directed scenarios for receive fifo, tx scheduling and abort
// assumes cmb_pkg and cmb_bus_model are compiled before this file
`timescale 1ns/1ps
module cmb_can_buffer_mgr_tb_top;
  import cmb_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, rx_irq, tx_irq, err_irq, rx_pin;
  logic [1:0]  htrans, port_pins_out, port_pins_oe;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic        ce, spare_pin;
  logic [2:0]  hsize;
  cmb_rx_evt_t rx_evt;
  cmb_tx_evt_t tx_evt;
  cmb_tx_ans_t tx_ans;
  int          bad_count = 0;
  int          checks_done = 0;

  cmb_can_buffer_mgr cmb_can_buffer_mgr_inst (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .port_pins_in({spare_pin, rx_pin}), .port_pins_out(port_pins_out),
    .port_pins_oe(port_pins_oe), .rx_evt(rx_evt), .tx_evt(tx_evt), .tx_ans(tx_ans), .rx_irq(rx_irq),
    .tx_irq(tx_irq), .err_irq(err_irq));
  cmb_bus_model cmb_bus_model_inst (
    .hclk(hclk), .tx_pin(port_pins_out[PIN_TX]), .rx_pin(rx_pin), .rx_evt(rx_evt), .tx_evt(tx_evt));

  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // hready is sampled before this edge's updates land, so the value seen is the one the edge used
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        bad_count++;
        give_verdict;
      end
      @(posedge hclk);
    end
  endtask
  task automatic ahb(input logic [11:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy;
    q = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    ahb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    ahb(a, 1'b0, 32'h0);
    chk(q, e);
  endtask

  task automatic t_reset;
    rd(TXFLG_OFF, 32'h7);
    rd(12'h1F0, 32'h0);
    chk({31'h0, port_pins_out[PIN_TX]}, 32'h1);
    chk({29'h0, hresp, port_pins_oe}, 32'h2);
    cmb_bus_model_inst.drive(1'b0);
    repeat (3) @(posedge hclk);
    chk({31'h0, tx_ans.rx_bit}, 32'h0);
    cmb_bus_model_inst.drive(1'b1);
  endtask
  // with the clock enable low the transmit pin must not follow the engine
  task automatic t_freeze;
    ce <= 1'b0;
    cmb_bus_model_inst.tx_pulse(9'h000);
    chk({31'h0, port_pins_out[PIN_TX]}, 32'h1);
    ce <= 1'b1;
    cmb_bus_model_inst.tx_pulse(9'h000);
    chk({31'h0, port_pins_out[PIN_TX]}, 32'h0);
  endtask
  task automatic t_rx;
    wr(MCTL_OFF, 32'h6);
    cmb_bus_model_inst.frame(8'h10, 1'b1, 1'b0);
    rd(RXFLG_OFF, 32'h1);
    chk({31'h0, rx_irq}, 32'h1);
    rd(12'h030, 32'h1C);
    // rejected frame lands in background only, then is overwritten by the next one
    cmb_bus_model_inst.frame(8'h20, 1'b0, 1'b0);
    cmb_bus_model_inst.frame(8'h30, 1'b1, 1'b0);
    cmb_bus_model_inst.frame(8'h40, 1'b1, 1'b0);
    rd(RXFLG_OFF, 32'h3);
    chk({31'h0, err_irq}, 32'h1);
    rd(12'h000, 32'h10);
    wr(RXFLG_OFF, 32'h1);
    rd(RXFLG_OFF, 32'h3);
    rd(12'h000, 32'h30);
    wr(RXFLG_OFF, 32'h3);
    rd(RXFLG_OFF, 32'h0);
  endtask
  task automatic t_own;
    cmb_bus_model_inst.frame(8'h50, 1'b1, 1'b1);
    rd(RXFLG_OFF, 32'h0);
    wr(MCTL_OFF, 32'h1);
    cmb_bus_model_inst.frame(8'h60, 1'b1, 1'b1);
    rd(RXFLG_OFF, 32'h1);
    chk({31'h0, rx_irq}, 32'h0);
    rd(12'h004, 32'h61);
    wr(RXFLG_OFF, 32'h1);
    wr(MCTL_OFF, 32'h0);
  endtask
  task automatic t_tx;
    wr(TXCTL_OFF, 32'h70);
    wr(12'h074, 32'h5);
    wr(12'h0B4, 32'h2);
    wr(12'h080, 32'hA5);
    wr(TXFLG_OFF, 32'h3);
    rd(TXFLG_OFF, 32'h4);
    cmb_bus_model_inst.tx_pulse(9'h101);
    chk({29'h0, tx_ans.busy, tx_ans.sel}, 32'h5);
    chk({31'h0, tx_ans.ack_allow}, 32'h0);
    cmb_bus_model_inst.tx_pulse(9'h005);
    chk({23'h0, tx_ans.busy, tx_ans.data}, 32'hA5);
    cmb_bus_model_inst.frame(8'h70, 1'b1, 1'b0);
    rd(RXFLG_OFF, 32'h1);
    wr(RXFLG_OFF, 32'h1);
    wr(12'h0F4, 32'h0);
    wr(TXFLG_OFF, 32'h4);
    cmb_bus_model_inst.tx_pulse(9'h101);
    chk({30'h0, tx_ans.sel}, 32'h2);
    cmb_bus_model_inst.tx_pulse(9'h003);
    cmb_bus_model_inst.tx_pulse(9'h101);
    chk({29'h0, tx_ans.busy, tx_ans.sel}, 32'h6);
    cmb_bus_model_inst.tx_pulse(9'h009);
    rd(TXFLG_OFF, 32'h4);
    chk({31'h0, tx_irq}, 32'h1);
    wr(TXCTL_OFF, 32'h71);
    rd(TXFLG_OFF, 32'h15);
    cmb_bus_model_inst.tx_pulse(9'h101);
    cmb_bus_model_inst.tx_pulse(9'h009);
    rd(TXFLG_OFF, 32'h17);
    wr(TXFLG_OFF, 32'h1);
    rd(TXFLG_OFF, 32'h6);
  endtask

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    ce = 1'b1;
    hsize = 3'h2;
    spare_pin = 1'b1;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_freeze;
    t_rx;
    t_own;
    t_tx;
    give_verdict;
  end
  initial
  begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    give_verdict;
  end
endmodule

// *** cmb_pkg.sv ***
// cmb_pkg: constants, register map and carrier types of the can message buffer manager
// assumes one 100 mhz clock domain shared with the protocol engine and the ahb-lite master
package cmb_pkg;
  localparam int          BUF_BYTES    = 13;       // bytes per message buffer
  localparam int          TX_BUFS      = 3;        // transmit buffers in the map
  localparam int          PIN_RX       = 0;        // port position of bus_receive_pin
  localparam int          PIN_TX       = 1;        // port position of bus_transmit_pin
  localparam logic        PIN_RECESSIVE = 1'b1;    // transmit level after reset
  // register map, byte addresses
  localparam logic [11:0] RX_BUF_OFF   = 12'h000;  // foreground_rx_buffer, one byte per word
  localparam logic [11:0] TX_BUF_OFF   = 12'h040;  // first tx buffer, 0x40 stride
  localparam logic [3:0]  LOCAL_PRIORITY_FIELD_IDX     = 4'hD;     // word of tx_buffer_priority_register in a tx window
  localparam logic [11:0] RXFLG_OFF    = 12'h100;  // receiver_flag_register
  localparam logic [11:0] TXFLG_OFF    = 12'h104;  // transmitter_flag_register
  localparam logic [11:0] TXCTL_OFF    = 12'h108;  // transmit_control_register
  localparam logic [11:0] MCTL_OFF     = 12'h10C;  // module_control_one
  localparam int          CTL_BIT      = 8;        // address bit that selects control registers
  localparam int          BSEL_MSB     = 7;
  localparam int          BSEL_LSB     = 6;
  localparam int          WIDX_MSB     = 5;
  localparam int          WIDX_LSB     = 2;
  // field positions
  localparam int          RXF_BIT      = 0;        // rx_full_flag
  localparam int          OVR_BIT      = 1;        // overrun flag
  localparam int          TXE_LSB      = 0;        // tx_empty_flag[2:0]
  localparam int          ABORT_ACK_FLAG_LSB    = 4;        // abort_ack_flag[6:4]
  localparam int          ABORT_REQUEST_FLAG_LSB    = 0;        // abort_request_flag[2:0]
  localparam int          TXIE_LSB     = 4;        // transmit interrupt enables[6:4]
  localparam int          LOOP_BIT     = 0;        // loop-back mode
  localparam int          RXIE_BIT     = 1;        // receive interrupt enable
  localparam int          OVRIE_BIT    = 2;        // overrun interrupt enable
  localparam logic        TXE_RST      = 1'b1;     // all tx buffers empty after reset

  typedef enum logic [1:0] {
    CMB_AHB_IDLE = 2'b00,
    CMB_AHB_WR   = 2'b01,
    CMB_AHB_RDW  = 2'b10,
    CMB_AHB_RD   = 2'b11
  } cmb_ahb_st_t;

  typedef struct packed {
    logic       sof;         // start of a frame on the bus
    logic       byte_valid;  // one received byte in data
    logic [7:0] data;
    logic       ok;          // frame completed without error
    logic       accept;      // identifier passed the acceptance filter
    logic       own;         // frame is our own transmission that won arbitration
  } cmb_rx_evt_t;

  typedef struct packed {
    logic       arb;         // engine arbitrates now and wants a buffer
    logic [3:0] rd_idx;      // byte index of the buffer being sent
    logic       done_ok;     // frame sent successfully
    logic       arb_lost;
    logic       error;
    logic       tx_bit;      // serial level to the transmit pin
  } cmb_tx_evt_t;

  typedef struct packed {
    logic       pending;     // a buffer is ready and none is in flight
    logic       busy;        // a buffer is in flight
    logic [1:0] sel;         // buffer in flight
    logic [7:0] data;        // byte at rd_idx, one cycle late
    logic       ack_allow;   // engine may acknowledge the current frame
    logic       rx_bit;      // synchronised receive level, or own level in loop-back
  } cmb_tx_ans_t;
endpackage
